//--- mwbl_consts.svh
`ifndef MWBL_CONSTS_SVH
`define MWBL_CONSTS_SVH
// ----------------------------------------
// register indices; byte address is four times
// ----------------------------------------
`define IDX_PAIR_HOLD 12'h00A4
`define IDX_TILT_EN 12'h0114
`define IDX_DISC_LED 12'h0115
`define IDX_BATT_LED 12'h011A
`define IDX_WHEEL_TYPE 12'h0137
`define IDX_WHEEL_FMT 12'h0138
`define IDX_WHEEL_INV 12'h0139
`define IDX_BATT_TIME 12'h0238
`define IDX_BATT_PRECONN 12'h0248
`define IDX_STATUS 12'h0300
`define IDX_SCROLL 12'h0301
// ----------------------------------------
// field positions
// ----------------------------------------
`define LED_EN_BIT 0
`define LED_PIN_BIT 1
`define LED_POL_BIT 2
`define LED_DUTY_LSB 4
`define LED_DUTY_MSB 7
`define BATT_SNIFF_LSB 8
`define BATT_SNIFF_MSB 10
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PAIR_HOLD 16'h00C8
`define RST_LED_CFG 11'h0_71
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 250
`define WHEEL_SAMPLE_US 2000
`define WHEEL_SAMPLE_CYC (`WHEEL_SAMPLE_US * `CLK_MHZ)
`define MS_TICK_CYC (1000 * `CLK_MHZ)
`define BLINK_SLOT_MS 16
`endif

//--- mwbl_pkg.sv
package mwbl_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  // battery led phase
  typedef enum logic [2:0] {
    BATT_IDLE = 3'b001,
    BATT_BLINK = 3'b010,
    BATT_REST = 3'b100
  } batt_state_t;
  // wheel reporting format
  typedef enum logic {
    FMT_HALF = 1'b0,
    FMT_QUARTER = 1'b1
  } wheel_fmt_t;
endpackage

//--- wheel_decoder.sv
`timescale 1ns/1ps
`include "mwbl_consts.svh"
module wheel_decoder #(
  parameter int SAMPLE_CYC = `WHEEL_SAMPLE_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // configuration
  input wire logic fmt_quarter_in,
  input wire logic invert_in,
  // encoder phases
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  // signed count pulse
  output logic step_out,
  output logic step_neg_out
);
  initial
  begin
    if (SAMPLE_CYC < 2) $error("sample period too short");
  end
  // ----------------------------------------
  // direction lookup on old and new state
  // ----------------------------------------
  // returns +1, -1 or 0 as {valid, negative}
  function automatic logic [1:0] dir(input logic [1:0] o, input logic [1:0] n);
    case ({o, n})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: dir = 2'b10;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: dir = 2'b11;
      default: dir = 2'b00;
    endcase
  endfunction
  logic [31:0] tick_cnt; // sampling divider
  logic [31:0] next_tick_cnt;
  logic [1:0] last_state; // previous sampled state
  logic [1:0] next_last_state;
  logic half_pend; // one half step waiting
  logic next_half_pend;
  logic half_neg; // direction of waiting step
  logic next_half_neg;
  logic next_step;
  logic next_step_neg;
  logic [1:0] cur;
  logic [1:0] d;
  // ----------------------------------------
  // sampling and counting
  // ----------------------------------------
  always_comb
  begin
    cur = {phase_b_in, phase_a_in}; // R4
    d = dir(last_state, cur); // R5
    next_tick_cnt = tick_cnt + 32'h0000_0001;
    next_last_state = last_state;
    next_half_pend = half_pend;
    next_half_neg = half_neg;
    next_step = 1'b0;
    next_step_neg = 1'b0;
    if (tick_cnt == 32'(SAMPLE_CYC - 1)) // R7
    begin
      next_tick_cnt = 32'h0000_0000;
      next_last_state = cur;
      if (d[1])
      begin
        // quarter counts each edge, half pairs them
        if (fmt_quarter_in) // R6
        begin
          next_step = 1'b1;
          next_step_neg = d[0] ^ invert_in; // R3
        end
        else if (half_pend && half_neg == d[0])
        begin
          next_step = 1'b1;
          next_step_neg = d[0] ^ invert_in; // R3
          next_half_pend = 1'b0;
        end
        else
        begin
          // a reversal restarts the pair
          next_half_pend = 1'b1;
          next_half_neg = d[0];
        end
      end
    end
  end
  // state registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick_cnt <= 32'h0000_0000;
      last_state <= 2'h0;
      half_pend <= 1'b0;
      half_neg <= 1'b0;
      step_out <= 1'b0;
      step_neg_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tick_cnt <= next_tick_cnt;
      last_state <= next_last_state;
      half_pend <= next_half_pend;
      half_neg <= next_half_neg;
      step_out <= next_step;
      step_neg_out <= next_step_neg;
    end
  end
endmodule

//--- led_driver.sv
`timescale 1ns/1ps
`include "mwbl_consts.svh"
module led_driver (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // timing
  input wire logic ms_tick_in,
  // request and duty
  input wire logic on_in,
  input wire logic [3:0] duty_in,
  // pwm level, before polarity
  output logic lit_out
);
  // ----------------------------------------
  // 16-step pwm, one step per ms
  // ----------------------------------------
  logic [3:0] phase; // pwm phase
  logic [3:0] next_phase;
  logic next_lit;
  // duty 0 keeps the led dark, 15 nearly always on
  always_comb
  begin
    next_phase = ms_tick_in ? phase + 4'h1 : phase;
    next_lit = on_in && (phase < duty_in);
  end
  // registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      phase <= 4'h0;
      lit_out <= 1'b0;
    end
    else if (ce_in)
    begin
      phase <= next_phase;
      lit_out <= next_lit;
    end
  end
endmodule

//--- mouse_wheel_button_led_ctrl.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "mwbl_consts.svh"
// Contract
// R1: wheel type picks mechanical or optical interface
// R2: report format picks half or quarter
// R3: invert flips sign of scroll counts
// R4: state is phase b high, phase a low
// R5: only defined steps produce counts
// R6: quarter counts all, half pairs steps
// R7: sample wheel phases every two milliseconds
// R8: tilt sensing only when tilt enabled
// R9: tilt pins become led outputs otherwise
// R10: pairing press valid after programmed hold
// R11: valid press starts pairing or unpairing
// R12: discover led per enable, pin, level, duty
// R13: leds only on two indicator pins
// R14: battery led lights on low battery
// R15: battery led per full configuration set
// R16: battery led off before connection option
module mouse_wheel_button_led_ctrl #(
  parameter int SAMPLE_CYC = `WHEEL_SAMPLE_CYC,
  parameter int MS_CYC = `MS_TICK_CYC
) (
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // wheel encoder
  input wire logic WHEEL_PHASE_A_IN,
  input wire logic WHEEL_PHASE_B_IN,
  output logic WHEEL_EMITTER_DRIVE_OUT,
  // tilt pins, shared with gp pins
  input wire logic TILT_INPUT_ONE_IN,
  input wire logic TILT_INPUT_TWO_IN,
  output logic GP_PIN_THREE_OUT,
  output logic GP_PIN_THREE_OE_OUT,
  output logic GP_PIN_FOUR_OUT,
  output logic GP_PIN_FOUR_OE_OUT,
  // pairing button, active low
  input wire logic PAIR_BUTTON_N_IN,
  // system state
  input wire logic DISCOVERABLE_IN,
  input wire logic LOW_BATTERY_IN,
  input wire logic HOST_CONNECTED_IN,
  input wire logic [2:0] SNIFF_MODE_IN,
  // indicator pins
  output logic INDICATOR_OUT_ZERO_OUT,
  output logic INDICATOR_OUT_ONE_OUT,
  // events and tilt levels
  output logic SCROLL_STEP_OUT,
  output logic SCROLL_NEG_OUT,
  output logic TILT_LEFT_OUT,
  output logic TILT_RIGHT_OUT,
  output logic PAIR_REQUEST_OUT
);
  initial
  begin
    if (MS_CYC < 1) $error("ms tick must be at least one cycle");
  end
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] pair_button_hold_time; // hold in ms
  logic [7:0] tilt_enable; // bit 0 enables tilt
  logic [7:0] wheel_type_select; // bit 0 optical
  logic [7:0] wheel_report_format; // bit 0 quarter
  logic [7:0] wheel_invert; // bit 0 invert
  logic [10:0] disc_led_cfg; // en, pin, pol, duty
  logic [10:0] batt_led_cfg; // plus sniff mask
  logic [15:0] batt_led_time; // blink, rest, total
  logic [7:0] batt_preconn_off; // bit 0 hold off
  logic [15:0] scroll_total; // signed running total
  logic [15:0] next_scroll_total;
  logic pair_sticky; // valid press seen
  logic next_pair_sticky;
  logic [31:0] next_prdata;
  logic apb_acc;
  logic apb_wr;
  logic mapped;
  // read mux and decode
  always_comb
  begin
    apb_acc = PSEL_IN && PENABLE_IN && CE_IN;
    apb_wr = apb_acc && PWRITE_IN;
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (1'b1)
      hit(PADDR_IN, `IDX_PAIR_HOLD): next_prdata[15:0] = pair_button_hold_time;
      hit(PADDR_IN, `IDX_TILT_EN): next_prdata[7:0] = tilt_enable;
      hit(PADDR_IN, `IDX_DISC_LED): next_prdata[10:0] = disc_led_cfg;
      hit(PADDR_IN, `IDX_BATT_LED): next_prdata[10:0] = batt_led_cfg;
      hit(PADDR_IN, `IDX_WHEEL_TYPE): next_prdata[7:0] = wheel_type_select;
      hit(PADDR_IN, `IDX_WHEEL_FMT): next_prdata[7:0] = wheel_report_format;
      hit(PADDR_IN, `IDX_WHEEL_INV): next_prdata[7:0] = wheel_invert;
      hit(PADDR_IN, `IDX_BATT_TIME): next_prdata[15:0] = batt_led_time;
      hit(PADDR_IN, `IDX_BATT_PRECONN): next_prdata[7:0] = batt_preconn_off;
      hit(PADDR_IN, `IDX_STATUS):
        next_prdata[3:0] = {pair_sticky, TILT_RIGHT_OUT, TILT_LEFT_OUT,
          LOW_BATTERY_IN};
      hit(PADDR_IN, `IDX_SCROLL): next_prdata[15:0] = scroll_total;
      default: mapped = 1'b0; // unmapped reads zero, errors
    endcase
  end
  // register file, zero wait states
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      pair_button_hold_time <= `RST_PAIR_HOLD;
      tilt_enable <= 8'h00;
      wheel_type_select <= 8'h00;
      wheel_report_format <= 8'h00;
      wheel_invert <= 8'h00;
      disc_led_cfg <= `RST_LED_CFG;
      batt_led_cfg <= `RST_LED_CFG;
      batt_led_time <= 16'h0000;
      batt_preconn_off <= 8'h00;
      PRDATA_OUT <= 32'h0000_0000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
      PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? next_prdata :
        32'h0000_0000;
      if (apb_wr && PREADY_OUT)
      begin
        if (hit(PADDR_IN, `IDX_PAIR_HOLD))
          pair_button_hold_time <= PWDATA_IN[15:0]; // R10
        if (hit(PADDR_IN, `IDX_TILT_EN))
          tilt_enable <= PWDATA_IN[7:0]; // R8
        if (hit(PADDR_IN, `IDX_DISC_LED))
          disc_led_cfg <= PWDATA_IN[10:0]; // R12
        if (hit(PADDR_IN, `IDX_BATT_LED))
          batt_led_cfg <= PWDATA_IN[10:0]; // R15
        if (hit(PADDR_IN, `IDX_WHEEL_TYPE))
          wheel_type_select <= PWDATA_IN[7:0]; // R1
        if (hit(PADDR_IN, `IDX_WHEEL_FMT))
          wheel_report_format <= PWDATA_IN[7:0]; // R2
        if (hit(PADDR_IN, `IDX_WHEEL_INV))
          wheel_invert <= PWDATA_IN[7:0]; // R3
        if (hit(PADDR_IN, `IDX_BATT_TIME))
          batt_led_time <= PWDATA_IN[15:0]; // R15
        if (hit(PADDR_IN, `IDX_BATT_PRECONN))
          batt_preconn_off <= PWDATA_IN[7:0]; // R16
      end
    end
  end
  // ----------------------------------------
  // wheel decoding
  // ----------------------------------------
  logic step; // one count
  logic step_neg; // count is negative
  wheel_decoder #(.SAMPLE_CYC(SAMPLE_CYC)) u_wheel (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CE_IN),
    .fmt_quarter_in(wheel_report_format[0]), // R2
    .invert_in(wheel_invert[0]),
    .phase_a_in(WHEEL_PHASE_A_IN),
    .phase_b_in(WHEEL_PHASE_B_IN),
    .step_out(step),
    .step_neg_out(step_neg)
  );
  // ----------------------------------------
  // ms tick, pairing timer, scroll total
  // ----------------------------------------
  logic [31:0] ms_cnt; // ms divider
  logic [31:0] next_ms_cnt;
  logic ms_tick;
  logic [15:0] hold_cnt; // ms held so far
  logic [15:0] next_hold_cnt;
  logic hold_done; // press already reported
  logic next_hold_done;
  logic next_pair_req;
  // a press counts once; releasing re-arms it
  always_comb
  begin
    ms_tick = (ms_cnt == 32'(MS_CYC - 1));
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    next_hold_cnt = hold_cnt;
    next_hold_done = hold_done;
    next_pair_req = 1'b0;
    if (PAIR_BUTTON_N_IN)
    begin
      next_hold_cnt = 16'h0000;
      next_hold_done = 1'b0;
    end
    else if (!hold_done && hold_cnt >= pair_button_hold_time) // R10
    begin
      next_pair_req = 1'b1; // R11
      next_hold_done = 1'b1;
    end
    else if (ms_tick && hold_cnt != 16'hFFFF)
      next_hold_cnt = hold_cnt + 16'h0001;
    // set wins over a read-clear
    next_pair_sticky = next_pair_req ||
      (pair_sticky && !(apb_acc && !PWRITE_IN && hit(PADDR_IN, `IDX_STATUS)));
    next_scroll_total = scroll_total;
    if (step)
      next_scroll_total = step_neg ? scroll_total - 16'h0001 :
        scroll_total + 16'h0001;
  end
  // timer registers
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      ms_cnt <= 32'h0000_0000;
      hold_cnt <= 16'h0000;
      hold_done <= 1'b0;
      pair_sticky <= 1'b0;
      PAIR_REQUEST_OUT <= 1'b0;
      scroll_total <= 16'h0000;
      SCROLL_STEP_OUT <= 1'b0;
      SCROLL_NEG_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      ms_cnt <= next_ms_cnt;
      hold_cnt <= next_hold_cnt;
      hold_done <= next_hold_done;
      pair_sticky <= next_pair_sticky;
      PAIR_REQUEST_OUT <= next_pair_req;
      scroll_total <= next_scroll_total;
      SCROLL_STEP_OUT <= step;
      SCROLL_NEG_OUT <= step_neg;
    end
  end
  // ----------------------------------------
  // battery led sequencing
  // ----------------------------------------
  mwbl_pkg::batt_state_t bstate; // blink phase
  mwbl_pkg::batt_state_t next_bstate;
  logic [7:0] seg_cnt; // ms within blink or rest
  logic [7:0] next_seg_cnt;
  logic [11:0] total_cnt; // ms since lamp started
  logic [11:0] next_total_cnt;
  logic batt_req;
  logic batt_on;
  logic disc_lit;
  logic batt_lit;
  // time fields in 16 ms slots: blink [3:0], rest [7:4], total [15:8]
  always_comb
  begin
    batt_req = batt_led_cfg[`LED_EN_BIT] && LOW_BATTERY_IN && // R14
      (|(batt_led_cfg[`BATT_SNIFF_MSB:`BATT_SNIFF_LSB] & SNIFF_MODE_IN)) &&
      !(batt_preconn_off[0] && !HOST_CONNECTED_IN); // R16
    next_bstate = bstate;
    next_seg_cnt = ms_tick ? seg_cnt + 8'h01 : seg_cnt;
    next_total_cnt = (ms_tick && total_cnt != 12'hFFF) ?
      total_cnt + 12'h001 : total_cnt;
    batt_on = 1'b0;
    case (bstate)
      mwbl_pkg::BATT_IDLE:
      begin
        next_seg_cnt = 8'h00;
        next_total_cnt = 12'h000;
        if (batt_req)
          next_bstate = mwbl_pkg::BATT_BLINK;
      end
      mwbl_pkg::BATT_BLINK:
      begin
        batt_on = 1'b1; // R15
        if (seg_cnt >= {batt_led_time[3:0], 4'h0})
        begin
          next_bstate = mwbl_pkg::BATT_REST;
          next_seg_cnt = 8'h00;
        end
      end
      mwbl_pkg::BATT_REST:
        if (seg_cnt >= {batt_led_time[7:4], 4'h0})
        begin
          next_bstate = mwbl_pkg::BATT_BLINK;
          next_seg_cnt = 8'h00;
        end
      default: next_bstate = mwbl_pkg::BATT_IDLE;
    endcase
    // total zero means no limit; dropping the request ends it
    if (!batt_req || (batt_led_time[15:8] != 8'h00 &&
        total_cnt >= {batt_led_time[15:8], 4'h0}))
      next_bstate = batt_req ? bstate : mwbl_pkg::BATT_IDLE;
  end
  // sequencer registers
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      bstate <= mwbl_pkg::BATT_IDLE;
      seg_cnt <= 8'h00;
      total_cnt <= 12'h000;
    end
    else if (CE_IN)
    begin
      bstate <= next_bstate;
      seg_cnt <= next_seg_cnt;
      total_cnt <= next_total_cnt;
    end
  end
  led_driver u_disc (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CE_IN),
    .ms_tick_in(ms_tick),
    .on_in(disc_led_cfg[`LED_EN_BIT] && DISCOVERABLE_IN), // R12
    .duty_in(disc_led_cfg[`LED_DUTY_MSB:`LED_DUTY_LSB]),
    .lit_out(disc_lit)
  );
  led_driver u_batt (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CE_IN),
    .ms_tick_in(ms_tick),
    .on_in(batt_on && !(total_cnt >= {batt_led_time[15:8], 4'h0} &&
      batt_led_time[15:8] != 8'h00)),
    .duty_in(batt_led_cfg[`LED_DUTY_MSB:`LED_DUTY_LSB]),
    .lit_out(batt_lit)
  );
  // ----------------------------------------
  // pins: indicators, tilt, emitter
  // ----------------------------------------
  logic lit0;
  logic lit1;
  always_comb
  begin
    // each led lands only on its chosen indicator pin
    lit0 = (disc_lit && !disc_led_cfg[`LED_PIN_BIT]) || // R13
      (batt_lit && !batt_led_cfg[`LED_PIN_BIT]);
    lit1 = (disc_lit && disc_led_cfg[`LED_PIN_BIT]) ||
      (batt_lit && batt_led_cfg[`LED_PIN_BIT]);
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      INDICATOR_OUT_ZERO_OUT <= 1'b0;
      INDICATOR_OUT_ONE_OUT <= 1'b0;
      TILT_LEFT_OUT <= 1'b0;
      TILT_RIGHT_OUT <= 1'b0;
      GP_PIN_THREE_OUT <= 1'b0;
      GP_PIN_THREE_OE_OUT <= 1'b0;
      GP_PIN_FOUR_OUT <= 1'b0;
      GP_PIN_FOUR_OE_OUT <= 1'b0;
      WHEEL_EMITTER_DRIVE_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      // polarity of the led owning the pin
      INDICATOR_OUT_ZERO_OUT <= lit0 ^ !(disc_led_cfg[`LED_PIN_BIT] ?
        batt_led_cfg[`LED_POL_BIT] : disc_led_cfg[`LED_POL_BIT]);
      INDICATOR_OUT_ONE_OUT <= lit1 ^ !(disc_led_cfg[`LED_PIN_BIT] ?
        disc_led_cfg[`LED_POL_BIT] : batt_led_cfg[`LED_POL_BIT]);
      // tilt pins are active-low inputs while enabled
      TILT_LEFT_OUT <= tilt_enable[0] && !TILT_INPUT_ONE_IN; // R8
      TILT_RIGHT_OUT <= tilt_enable[0] && !TILT_INPUT_TWO_IN;
      // otherwise driven low as spare led outputs
      GP_PIN_THREE_OE_OUT <= !tilt_enable[0]; // R9
      GP_PIN_FOUR_OE_OUT <= !tilt_enable[0];
      GP_PIN_THREE_OUT <= 1'b0;
      GP_PIN_FOUR_OUT <= 1'b0;
      WHEEL_EMITTER_DRIVE_OUT <= wheel_type_select[0]; // R1
    end
  end
endmodule

//--- wheel_encoder_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// quadrature wheel encoder, levels held
// ----------------------------------------
module wheel_encoder_model (
  // clock
  input wire logic clk_in,
  // phase levels
  output logic phase_a_out,
  output logic phase_b_out
);
  logic [1:0] pos = 2'b00; // detent position, mod 4
  // moves on a rising edge; 2 jumps both phases at once
  task automatic move(input int d);
    @(posedge clk_in);
    pos <= pos + d[1:0];
  endtask
  // gray order of {b,a}: 00, 01, 11, 10 going forward
  always_comb
  begin
    phase_b_out = pos[1];
    phase_a_out = pos[1] ^ pos[0];
  end
endmodule

//--- mwbl_checker.sv
`timescale 1ns/1ps
module mwbl_checker #(
  parameter int SAMPLE_CYC = 8,
  parameter int MS_CYC = 4
) (
  // clock, reset, bus
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // wheel, tilt, button
  input wire logic WHEEL_PHASE_A_IN,
  input wire logic WHEEL_PHASE_B_IN,
  input wire logic WHEEL_EMITTER_DRIVE_OUT,
  input wire logic GP_PIN_THREE_OE_OUT,
  input wire logic TILT_LEFT_OUT,
  input wire logic TILT_RIGHT_OUT,
  input wire logic PAIR_BUTTON_N_IN,
  input wire logic PAIR_REQUEST_OUT,
  input wire logic SCROLL_STEP_OUT
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic wr_ok; // write lands
  logic emit_exp; // mirror of wheel type bit 0
  logic [15:0] hold_exp; // mirror of hold time
  logic [1:0] ph_q; // last phase pair
  int low_cnt; // button low cycles
  int qcnt; // since phase change
  assign wr_ok = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  // bus mirrors, phase and button counters
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      emit_exp <= 1'b0;
      hold_exp <= 16'h00C8;
      ph_q <= 2'b00;
      low_cnt <= 0;
      qcnt <= 0;
    end
    else
    begin
      if (wr_ok && PADDR_IN == 16'h04DC)
        emit_exp <= PWDATA_IN[0];
      if (wr_ok && PADDR_IN == 16'h0290)
        hold_exp <= PWDATA_IN[15:0];
      ph_q <= {WHEEL_PHASE_B_IN, WHEEL_PHASE_A_IN};
      low_cnt <= PAIR_BUTTON_N_IN ? 0 : low_cnt + 1;
      qcnt <= (ph_q != {WHEEL_PHASE_B_IN, WHEEL_PHASE_A_IN}) ? 0 :
        ((qcnt < 255) ? qcnt + 1 : qcnt);
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  apb_answer_a: assert property (PSEL_IN && !PENABLE_IN && CE_IN
    |=> PREADY_OUT) else $error("no answer");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  err_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  emitter_type_a: assert property (
    wr_ok && PADDR_IN == 16'h04DC |-> ##2
    WHEEL_EMITTER_DRIVE_OUT == emit_exp) else $error("emitter wrong");
  tilt_gate_a: assert property (
    (TILT_LEFT_OUT || TILT_RIGHT_OUT) |-> !GP_PIN_THREE_OE_OUT)
    else $error("tilt while outputs");
  step_period_a: assert property (
    SCROLL_STEP_OUT |=> !SCROLL_STEP_OUT [*7])
    else $error("steps too close");
  step_cause_a: assert property (
    SCROLL_STEP_OUT |-> qcnt <= SAMPLE_CYC + 6)
    else $error("step without phase change");
  pair_hold_a: assert property (
    PAIR_REQUEST_OUT |-> low_cnt >= (int'(hold_exp) - 1) * MS_CYC)
    else $error("pair too early");
  pair_once_a: assert property (
    PAIR_REQUEST_OUT |=> !PAIR_REQUEST_OUT) else $error("pair too wide");
  step_c: cover property (SCROLL_STEP_OUT);
  pair_c: cover property (PAIR_REQUEST_OUT);
  err_c: cover property (PSLVERR_OUT);
endmodule

//--- mouse_wheel_button_led_ctrl_tb.sv
`timescale 1ns/1ps
module mouse_wheel_button_led_ctrl_tb;
  logic CLK_IN = 0, RSTN_IN = 0, CE_IN = 1, PSEL_IN = 0, PENABLE_IN = 0;
  logic PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT, WHEEL_PHASE_A_IN;
  logic [15:0] PADDR_IN = 16'h0000;
  logic [31:0] PWDATA_IN = 32'h0000_0000, PRDATA_OUT;
  logic WHEEL_PHASE_B_IN, WHEEL_EMITTER_DRIVE_OUT, GP_PIN_THREE_OUT;
  logic TILT_INPUT_ONE_IN = 1, TILT_INPUT_TWO_IN = 1, GP_PIN_THREE_OE_OUT;
  logic GP_PIN_FOUR_OUT, GP_PIN_FOUR_OE_OUT, PAIR_BUTTON_N_IN = 1;
  logic DISCOVERABLE_IN = 0, LOW_BATTERY_IN = 0, HOST_CONNECTED_IN = 0;
  logic [2:0] SNIFF_MODE_IN = 3'b001;
  logic INDICATOR_OUT_ZERO_OUT, INDICATOR_OUT_ONE_OUT, SCROLL_STEP_OUT;
  logic SCROLL_NEG_OUT, TILT_LEFT_OUT, TILT_RIGHT_OUT, PAIR_REQUEST_OUT;
  int n_errors = 0, checks_done = 0;
  always #2 CLK_IN = ~CLK_IN; // 250 MHz
  mouse_wheel_button_led_ctrl #(.SAMPLE_CYC(8), .MS_CYC(4))
    u_mouse_wheel_button_led_ctrl (.*);
  wheel_encoder_model u_wheel_encoder_model (.clk_in(CLK_IN),
    .phase_a_out(WHEEL_PHASE_A_IN), .phase_b_out(WHEEL_PHASE_B_IN));
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  // one apb transfer
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int t = 0;
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    @(posedge CLK_IN);
    while (PREADY_OUT !== 1'b1 && t < 50)
    begin
      @(posedge CLK_IN);
      t++;
    end
    if (t == 50)
      n_errors++;
    r = PRDATA_OUT;
    e = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("read data", x, r);
    chk("slverr", {31'b0, xe}, {31'b0, e});
  endtask
  // move wheel, count pulses
  task automatic wheel(input int mv, input int n, input logic neg);
    int c = 0;
    logic s = 1'b0;
    u_wheel_encoder_model.move(mv);
    repeat (24)
    begin
      @(negedge CLK_IN);
      if (SCROLL_STEP_OUT === 1'b1)
      begin
        c++;
        s = SCROLL_NEG_OUT;
      end
    end
    chk("scroll count", n, c);
    if (n > 0)
      chk("scroll sign", {31'b0, neg}, {31'b0, s});
  endtask
  // lit seen per pin, after settling
  task automatic leds(input int xz, input int xo);
    int z = 0;
    int o = 0;
    repeat (4) @(posedge CLK_IN);
    repeat (600)
    begin
      @(negedge CLK_IN);
      z += (INDICATOR_OUT_ZERO_OUT === 1'b1);
      o += (INDICATOR_OUT_ONE_OUT === 1'b1);
    end
    chk("pin zero lit", xz, (z > 0));
    chk("pin one lit", xo, (o > 0));
  endtask
  task automatic test_regs();
    rd(16'h0290, 32'h0000_00C8, 1'b0);
    rd(16'h0450, 32'h0000_0000, 1'b0);
    rd(16'h04DC, 32'h0000_0000, 1'b0);
    rd(16'h04E0, 32'h0000_0000, 1'b0);
    rd(16'h04E4, 32'h0000_0000, 1'b0);
    rd(16'h0FF0, 32'h0000_0000, 1'b1);
    wr(16'h04DC, 32'h0000_0001);
    rd(16'h04DC, 32'h0000_0001, 1'b0);
    chk("emitter", 1, WHEEL_EMITTER_DRIVE_OUT);
    wr(16'h04DC, 32'h0000_0000);
    $display("register test done");
  endtask
  task automatic test_wheel();
    wheel(1, 0, 0);
    wheel(1, 1, 0);
    wheel(-1, 0, 0);
    wheel(-1, 1, 1);
    wr(16'h04E0, 32'h0000_0001);
    wheel(1, 1, 0);
    wheel(2, 0, 0);
    wheel(2, 0, 0);
    wheel(-1, 1, 1);
    wr(16'h04E4, 32'h0000_0001);
    wheel(1, 1, 1);
    wheel(-1, 1, 0);
    $display("wheel test done");
  endtask
  task automatic test_tilt();
    chk("gp oe", 1, GP_PIN_THREE_OE_OUT & GP_PIN_FOUR_OE_OUT);
    wr(16'h0450, 32'h0000_0001);
    repeat (2) @(negedge CLK_IN);
    chk("gp oe", 0, GP_PIN_THREE_OE_OUT | GP_PIN_FOUR_OE_OUT);
    TILT_INPUT_ONE_IN <= 1'b0;
    repeat (10) @(posedge CLK_IN);
    chk("tilt seen", 1, TILT_LEFT_OUT | TILT_RIGHT_OUT);
    wr(16'h0450, 32'h0000_0000);
    repeat (10) @(posedge CLK_IN);
    chk("tilt masked", 0, TILT_LEFT_OUT | TILT_RIGHT_OUT);
    TILT_INPUT_ONE_IN <= 1'b1;
    $display("tilt test done");
  endtask
  task automatic test_pair();
    int c = 0;
    int f = 0;
    wr(16'h0290, 32'h0000_0003);
    PAIR_BUTTON_N_IN <= 1'b0;
    for (int i = 0; i < 120; i++)
    begin
      @(negedge CLK_IN);
      if (PAIR_REQUEST_OUT === 1'b1)
      begin
        c++;
        f = i;
      end
    end
    chk("pair pulses", 1, c);
    chk("pair not early", 1, (f >= 8));
    PAIR_BUTTON_N_IN <= 1'b1;
    $display("pair test done");
  endtask
  task automatic test_leds();
    wr(16'h0454, 32'h0000_0075);
    wr(16'h0468, 32'h0000_0777);
    wr(16'h08E0, 32'h0000_0011);
    wr(16'h0920, 32'h0000_0001);
    LOW_BATTERY_IN <= 1'b1;
    leds(0, 0);
    HOST_CONNECTED_IN <= 1'b1;
    leds(0, 1);
    LOW_BATTERY_IN <= 1'b0;
    DISCOVERABLE_IN <= 1'b1;
    leds(1, 0);
    $display("led test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #80000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge CLK_IN);
    RSTN_IN <= 1'b1;
    test_regs();
    test_wheel();
    test_tilt();
    test_pair();
    test_leds();
    finish_test();
  end
endmodule
bind mouse_wheel_button_led_ctrl mwbl_checker #(.SAMPLE_CYC(SAMPLE_CYC),
  .MS_CYC(MS_CYC)) u_mwbl_checker (.*);
